// ### hdl/sep_device.sv
// device end: two-wire slave with read, address set and busy polling
// assumes: scl/sda come asynchronously from the bus; one 100 MHz clock
`timescale 1ns/10ps
module sep_device #(
  parameter int unsigned PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  sep_bus_if.device       bus,
  output logic [15:0]     mem_addr,
  input  wire logic [7:0] mem_rdata,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic [7:0]      wr_data,
  output logic            busy
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK,
                ST_TX, ST_TX_ACK, ST_SKIP} sep_state_type;
  // ***********************************************************
  // input synchronisers and bus events
  // ***********************************************************
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic       scl_d_reg, sda_d_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else if (clk_en) begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end
  wire scl_s   = scl_sync_reg[1];
  wire sda_s   = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // ***********************************************************
  // protocol state
  // ***********************************************************
  sep_state_type state_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_reg;
  logic        rw_reg, match_reg, sda_oe_reg;
  logic [1:0]  byte_idx_reg;      // 0,1 word address bytes, 2 data
  logic [15:0] addr_reg, waddr_reg;
  logic        wrote_reg;         // data byte loaded this frame
  logic [31:0] prog_cnt_reg;
  logic        ack_ok;
  wire [6:0]   id_in = shift_reg[6:0];
  wire         id_hit = (id_in == sep_pkg::SLAVE_ARRAY_ID) ||
                        (id_in == sep_pkg::SLAVE_CCR_ID);
  wire         prog_done = (prog_cnt_reg == 32'h0);
  assign busy     = ~prog_done;
  assign mem_addr = addr_reg;
  assign bus.sda_oe_s = sda_oe_reg;
  // write data goes through the buffer; a byte the full buffer refuses is nacked and not stored
  logic buf_in_valid, buf_in_ready, took_reg;
  assign buf_in_valid = (state_reg == ST_RX) && scl_rise && (bit_reg == 4'h7)
                        && (byte_idx_reg == 2'h2);
  // a data byte is acked only if the buffer really took it
  always_comb ack_ok = (byte_idx_reg != 2'h2) | took_reg;
  sep_skid_buf u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({shift_reg[6:0], sda_s}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_data)
  );
  // programming timer: loaded by the closing stop, busy only until zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) prog_cnt_reg <= 32'h0;
    else if (clk_en) begin
      // the stop clock itself counts one rise; more means a cut data byte
      if (stop_ev && wrote_reg && (state_reg != ST_RX || bit_reg < 4'h2)) begin
        prog_cnt_reg <= PROG_CYCLES;
      end else if (!prog_done) begin
        prog_cnt_reg <= prog_cnt_reg - 32'h1;
      end
    end
  end
  // main sequencer on synchronised scl edges
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      shift_reg    <= 8'h00;
      bit_reg      <= 4'h0;
      rw_reg       <= 1'b0;
      match_reg    <= 1'b0;
      sda_oe_reg   <= 1'b0;
      byte_idx_reg <= 2'h0;
      addr_reg     <= sep_pkg::ADDR_RESET;
      waddr_reg    <= sep_pkg::ADDR_RESET;
      wrote_reg    <= 1'b0;
      took_reg     <= 1'b0;
    end else if (clk_en) begin
      if (start_ev) begin
        state_reg  <= ST_ADDR;
        bit_reg    <= 4'h0;
        sda_oe_reg <= 1'b0;
      end else if (stop_ev) begin
        // standby until the next start
        if (byte_idx_reg == 2'h2 && !rw_reg && match_reg && !wrote_reg) begin
          addr_reg <= waddr_reg;
        end
        state_reg  <= ST_IDLE;
        sda_oe_reg <= 1'b0;
        wrote_reg  <= 1'b0;
        match_reg  <= 1'b0;
        byte_idx_reg <= 2'h0;
      end else begin
        case (state_reg)
          ST_IDLE: ;
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_reg   <= bit_reg + 4'h1;
            end
            if (buf_in_valid) took_reg <= buf_in_ready;
            if (scl_fall && bit_reg == 4'h8) begin
              bit_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                rw_reg <= shift_reg[0];
                // busy device ignores its own address
                if (shift_reg[7:1] == sep_pkg::SLAVE_ARRAY_ID ||
                    shift_reg[7:1] == sep_pkg::SLAVE_CCR_ID) begin
                  match_reg  <= prog_done;
                  sda_oe_reg <= prog_done;
                  state_reg  <= prog_done ? ST_ADDR_ACK : ST_SKIP;
                  if (!shift_reg[0]) byte_idx_reg <= 2'h0;
                  // read after a dummy write: counter settles before the first fetch
                  if (shift_reg[0] && byte_idx_reg == 2'h2 && prog_done) begin
                    addr_reg <= waddr_reg;
                  end
                end else begin
                  state_reg <= ST_SKIP;
                end
              end else begin
                if (byte_idx_reg == 2'h0) waddr_reg[15:8] <= shift_reg;
                if (byte_idx_reg == 2'h1) waddr_reg[7:0]  <= shift_reg;
                if (byte_idx_reg == 2'h2) begin
                  wrote_reg <= ack_ok;
                  waddr_reg <= waddr_reg + 16'h1;
                end else begin
                  byte_idx_reg <= byte_idx_reg + 2'h1;
                end
                sda_oe_reg <= ack_ok;
                state_reg  <= ST_RX_ACK;
              end
            end
          end
          ST_ADDR_ACK, ST_RX_ACK: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              if (state_reg == ST_ADDR_ACK && rw_reg) begin
                // any read: counter already holds the current or the supplied address
                byte_idx_reg <= 2'h0;
                shift_reg    <= mem_rdata;
                state_reg    <= ST_TX;
                sda_oe_reg   <= ~mem_rdata[7];
                bit_reg      <= 4'h1;
              end else begin
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_reg == 4'h8) begin
                sda_oe_reg <= 1'b0;
                state_reg  <= ST_TX_ACK;
                addr_reg   <= addr_reg + 16'h1;
              end else begin
                sda_oe_reg <= ~shift_reg[3'h7 - bit_reg[2:0]];
                bit_reg    <= bit_reg + 4'h1;
              end
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) begin
              // master ack asks for next byte; nack ends transmission
              state_reg <= sda_s ? ST_SKIP : ST_TX;
              bit_reg   <= 4'h0;
            end
            if (state_reg == ST_TX && scl_fall) state_reg <= ST_TX;
          end
          ST_SKIP: ;
          default: state_reg <= ST_IDLE;
        endcase
        // load next byte at the fall that ends the ack clock
        if (state_reg == ST_TX && bit_reg == 4'h0 && scl_fall) begin
          shift_reg  <= mem_rdata;
          sda_oe_reg <= ~mem_rdata[7];
          bit_reg    <= 4'h1;
        end
      end
    end
  end
endmodule // sep_device

// ### hdl/sep_pkg.sv
// package: shared constants for the two-wire read/poll link
// assumes: both ends and the testbench compile this first
package sep_pkg;
  // ***********************************************************
  // addressing
  // ***********************************************************
  localparam logic [6:0] SLAVE_ARRAY_ID = 7'h57;   // 1010111
  localparam logic [6:0] SLAVE_CCR_ID   = 7'h6F;   // 1101111, clock_control_register_space
  localparam logic [15:0] ADDR_RESET    = 16'h0000;
  localparam int unsigned ADDR_W        = 16;
  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned PROG_TIME_US   = 5000;   // programming cycle, 5 ms
  localparam int unsigned PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned SCL_HALF_CYC   = 50;     // quarter bit time in clocks, plain default
  // ***********************************************************
  // host commands
  // ***********************************************************
  typedef enum logic [1:0] {
    SEP_CMD_CUR_READ,
    SEP_CMD_RAND_READ,
    SEP_CMD_SET_ADDR,
    SEP_CMD_WRITE
  } sep_cmd_type;
endpackage

// ### hdl/sep_bus_if.sv
// interface: the shared scl/sda wires between host and device
// assumes: open-drain lines with pull-ups, resolved here from enables
`timescale 1ns/10ps
interface sep_bus_if;
  logic scl_oe;     // host pulls scl low
  logic sda_oe_m;   // host pulls sda low
  logic sda_oe_s;   // device pulls sda low
  logic scl;
  logic sda;
  // wired-and of open-drain drivers
  assign scl = ~scl_oe;
  assign sda = ~(sda_oe_m | sda_oe_s);
  modport host   (output scl_oe, output sda_oe_m, input scl, input sda);
  modport device (output sda_oe_s, input scl, input sda);
endinterface

// ### hdl/sep_skid_buf.sv
// two-entry buffer with valid/ready on both sides
// assumes: single clock, synchronous active-low reset
`timescale 1ns/10ps
module sep_skid_buf (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  logic [7:0] mem_reg [0:1];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] cnt_reg;
  wire        push = in_valid & in_ready;
  wire        pop  = out_valid & out_ready;
  // honest flags straight from the fill count
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];
  // pointers and storage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
    end else if (clk_en) begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // sep_skid_buf

// ### hdl/sep_host.sv
// host end: two-wire master issuing reads, address sets and polling
// assumes: open-drain bus resolved in the interface; one 100 MHz clock
`timescale 1ns/10ps
module sep_host (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  sep_bus_if.host                bus,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire sep_pkg::sep_cmd_type cmd_op,
  input  wire logic              cmd_ccr,
  input  wire logic [15:0]       cmd_addr,
  input  wire logic [7:0]        cmd_len,
  input  wire logic [7:0]        cmd_wdata,
  output logic                   rd_valid,
  output logic [7:0]             rd_data,
  output logic                   done
);
  typedef enum {H_IDLE, H_START, H_BYTE, H_ACK, H_STOP} sep_hstate_type;
  sep_hstate_type state_reg;
  logic [7:0]  cnt_reg;
  logic [1:0]  phase_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  sh_reg;
  logic [2:0]  step_reg;     // 0 addr-w,1 hi,2 lo,3 data,4 addr-r,5 read
  logic        rx_reg;
  logic        restart_reg;
  logic [7:0]  left_reg;
  logic        scl_oe_reg, sda_oe_reg;
  logic [1:0]  sda_sync_reg;
  sep_pkg::sep_cmd_type op_reg;
  logic        ccr_reg;
  logic [15:0] addr_reg;
  logic [7:0]  wdat_reg;
  wire  [6:0]  id = ccr_reg ? sep_pkg::SLAVE_CCR_ID : sep_pkg::SLAVE_ARRAY_ID;
  wire         tick = (cnt_reg == 8'(sep_pkg::SCL_HALF_CYC - 1));
  wire         sda_in = sda_sync_reg[1];
  assign bus.scl_oe   = scl_oe_reg;
  assign bus.sda_oe_m = sda_oe_reg;
  assign cmd_ready    = (state_reg == H_IDLE);
  // sda sampled through two flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) sda_sync_reg <= 2'h3;
    else if (clk_en) sda_sync_reg <= {sda_sync_reg[0], bus.sda};
  end
  // bit engine: four phases per bit, scl low on phases 0,1
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= H_IDLE; cnt_reg <= 8'h00; phase_reg <= 2'h0;
      bit_reg <= 4'h0; sh_reg <= 8'h00; step_reg <= 3'h0; rx_reg <= 1'b0;
      restart_reg <= 1'b0; left_reg <= 8'h00; scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0; rd_valid <= 1'b0; rd_data <= 8'h00; done <= 1'b0;
      op_reg <= sep_pkg::SEP_CMD_CUR_READ; ccr_reg <= 1'b0;
      addr_reg <= 16'h0000; wdat_reg <= 8'h00;
    end else if (clk_en) begin
      rd_valid <= 1'b0;
      done     <= 1'b0;
      cnt_reg  <= tick ? 8'h00 : cnt_reg + 8'h1;
      if (state_reg == H_IDLE) begin
        if (cmd_valid) begin
          op_reg <= cmd_op; ccr_reg <= cmd_ccr; addr_reg <= cmd_addr;
          wdat_reg <= cmd_wdata; left_reg <= cmd_len;
          step_reg <= (cmd_op == sep_pkg::SEP_CMD_CUR_READ) ? 3'h4 : 3'h0;
          state_reg <= H_START; phase_reg <= 2'h0; cnt_reg <= 8'h00;
        end
      end else if (tick) begin
        phase_reg <= phase_reg + 2'h1;
        case (state_reg)
          H_START: begin
            // sda high, scl high, then sda low
            case (phase_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              default: begin
                scl_oe_reg <= 1'b1;
                sh_reg <= (step_reg == 3'h4) ? {id, 1'b1} : {id, 1'b0};
                rx_reg <= 1'b0; bit_reg <= 4'h0; state_reg <= H_BYTE;
              end
            endcase
          end
          H_BYTE, H_ACK: begin
            case (phase_reg)
              2'h0: if (state_reg == H_ACK)
                      sda_oe_reg <= rx_reg && left_reg != 8'h1;  // ack asks for more
                    else sda_oe_reg <= rx_reg ? 1'b0 : ~sh_reg[7];
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: if (state_reg == H_BYTE) sh_reg <= {sh_reg[6:0], sda_in};
              default: begin
                scl_oe_reg <= 1'b1;
                if (state_reg == H_BYTE) begin
                  bit_reg <= bit_reg + 4'h1;
                  if (bit_reg == 4'h7) begin
                    state_reg <= H_ACK;
                    if (rx_reg) begin rd_valid <= 1'b1; rd_data <= sh_reg; end
                  end
                end else begin
                  state_reg <= H_BYTE; bit_reg <= 4'h0;
                  if (rx_reg) begin
                    left_reg <= left_reg - 8'h1;
                    if (left_reg == 8'h1) state_reg <= H_STOP;   // nack then stop
                  end else if (sda_in) begin
                    state_reg <= H_STOP; restart_reg <= 1'b1;    // no ack: poll again
                  end else begin
                    case (step_reg)
                      3'h0: begin sh_reg <= addr_reg[15:8]; step_reg <= 3'h1;
                        if (op_reg == sep_pkg::SEP_CMD_CUR_READ) state_reg <= H_STOP; end
                      3'h1: begin sh_reg <= addr_reg[7:0]; step_reg <= 3'h2; end
                      3'h2: begin
                        if (op_reg == sep_pkg::SEP_CMD_WRITE) begin
                          sh_reg <= wdat_reg; step_reg <= 3'h3;
                        end else if (op_reg == sep_pkg::SEP_CMD_RAND_READ) begin
                          step_reg <= 3'h4; state_reg <= H_START;  // repeated start
                        end else state_reg <= H_STOP;
                      end
                      3'h4: begin rx_reg <= 1'b1; step_reg <= 3'h5; sda_oe_reg <= 1'b0; end
                      default: state_reg <= H_STOP;
                    endcase
                  end
                end
              end
            endcase
          end
          H_STOP: begin
            case (phase_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              default: begin
                if (restart_reg) begin
                  restart_reg <= 1'b0; state_reg <= H_START;
                  step_reg <= (op_reg == sep_pkg::SEP_CMD_CUR_READ) ? 3'h4 : 3'h0;
                end else begin
                  state_reg <= H_IDLE; done <= 1'b1;
                end
              end
            endcase
          end
          default: state_reg <= H_IDLE;
        endcase
      end
    end
  end
endmodule // sep_host

// ### tb/sep_props.sv
// checker: two-wire bus relations between the host and device ends
// assumes: tb instantiates it beside the bus interface, one clock
`timescale 1ns/10ps
module sep_props #(
  parameter int unsigned PROG_CYCLES = 2000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire logic busy
);
  // ****************
  // bus tracking
  // ****************
  logic        scl_reg, sda_reg, ack0_reg, quiet_reg, busy0_reg;
  logic [3:0]  bit_reg;
  logic [2:0]  byte_reg;
  logic [6:0]  sh_reg;
  logic [7:0]  hdr_reg, stop_age_reg;
  logic [31:0] busy_cnt_reg;
  // bus events from one cycle of history
  wire scl_rise = scl & ~scl_reg;
  wire start_ev = scl & scl_reg & sda_reg & ~sda;
  wire stop_ev  = scl & scl_reg & ~sda_reg & sda;
  wire ninth    = scl_rise & (bit_reg == 4'h8);
  wire addr9    = ninth & (byte_reg == 3'h0);
  wire rd9      = ninth & (byte_reg != 3'h0) & hdr_reg[0] & ack0_reg;
  wire id_ok    = hdr_reg[7:1] == sep_pkg::SLAVE_ARRAY_ID || hdr_reg[7:1] == sep_pkg::SLAVE_CCR_ID;
  // history resets high so reset release shows no false edge
  always_ff @(posedge core_clk) begin
    scl_reg <= scl | ~rst_n;
    sda_reg <= sda | ~rst_n;
    busy_cnt_reg <= busy ? busy_cnt_reg + 32'h1 : 32'h0;
    stop_age_reg <= !rst_n ? 8'hFF : stop_ev ? 8'h00 : stop_age_reg + {7'h00, ~&stop_age_reg};
  end
  // bit and byte position since the last start
  always_ff @(posedge core_clk) begin
    if (!rst_n || start_ev) begin
      bit_reg  <= 4'h0;
      byte_reg <= 3'h0;
    end else if (scl_rise) begin
      bit_reg  <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
      byte_reg <= (bit_reg == 4'h8 && byte_reg != 3'h7) ? byte_reg + 3'h1 : byte_reg;
    end
  end
  // header byte and its acknowledge
  always_ff @(posedge core_clk) begin
    if (scl_rise) sh_reg <= {sh_reg[5:0], sda};
    if (scl_rise && byte_reg == 3'h0 && bit_reg == 4'h7) hdr_reg <= {sh_reg, sda};
    ack0_reg <= !rst_n ? 1'b0 : addr9 ? ~sda : ack0_reg;
  end
  // silence owed after a refused address or a refused read byte
  always_ff @(posedge core_clk) begin
    quiet_reg <= !rst_n || start_ev ? 1'b0 : quiet_reg | (sda & (addr9 | rd9));
    busy0_reg <= !rst_n ? 1'b0 : start_ev ? busy : busy0_reg | busy;
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_ACK_MATCH: assert property (addr9 && id_ok && !busy0_reg |-> sda_oe_s)
    else $error("matching address not acknowledged");
  AST_NACK_MISMATCH: assert property (addr9 && !id_ok |-> !sda_oe_s)
    else $error("foreign address acknowledged");
  AST_NACK_BUSY: assert property (addr9 && busy |-> !sda_oe_s)
    else $error("address acknowledged while programming");
  AST_ACK_WORD: assert property (ninth && byte_reg inside {3'h1, 3'h2} && !hdr_reg[0] && ack0_reg
    |-> sda_oe_s)
    else $error("word address byte not acknowledged");
  AST_READ_RELEASE: assert property (rd9 |-> !sda_oe_s)
    else $error("device held sda in the acknowledge slot");
  AST_QUIET: assert property (quiet_reg |-> !sda_oe_s)
    else $error("device drove sda after a refusal");
  AST_BUSY_AFTER_STOP: assert property ($rose(busy) |-> stop_age_reg < 8'h10)
    else $error("programming began without a stop");
  AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_reg == PROG_CYCLES)
    else $error("programming time wrong");
  AST_SDA_SCL_LOW: assert property (!$stable(sda_oe_s) |-> !scl)
    else $error("device changed sda while scl high");
  CVR_POLL_NACK: cover property (addr9 && busy);
  CVR_SEQ_ACK: cover property (rd9 && sda_oe_m);
  CVR_BUSY_END: cover property ($fell(busy));
endmodule // sep_props

// ### tb/tb.sv
// testbench: host and device ends joined by the bus interface
// assumes: package, interface and both ends are compiled first
`timescale 1ns/10ps
module tb;
  localparam int unsigned PROG_CYC  = 2000;   // short programming time for sim
  localparam int          CYC_LIMIT = 60000;
  logic                 core_clk, rst_n, clk_en, cmd_valid, cmd_ccr, wr_ready;
  logic                 cmd_ready, rd_valid, done, wr_valid, busy;
  logic [15:0]          cmd_addr, mem_addr;
  logic [7:0]           cmd_len, cmd_wdata, rd_data, mem_rdata, wr_data;
  sep_pkg::sep_cmd_type cmd_op;
  logic [7:0]           rd_q[$];
  int                   err_count, compares, cyc_count;
  // ****************
  // structure
  // ****************
  sep_bus_if i_sep_bus_if ();
  sep_host i_sep_host (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .bus(i_sep_bus_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_ccr(cmd_ccr),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done));
  sep_device #(.PROG_CYCLES(PROG_CYC)) i_sep_device (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .bus(i_sep_bus_if), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .busy(busy));
  sep_props #(.PROG_CYCLES(PROG_CYC)) i_sep_props (.core_clk(core_clk), .rst_n(rst_n),
    .scl(i_sep_bus_if.scl), .sda(i_sep_bus_if.sda), .sda_oe_m(i_sep_bus_if.sda_oe_m),
    .sda_oe_s(i_sep_bus_if.sda_oe_s), .busy(busy));
  // memory stand-in: distinct bytes at both ends of the address space
  function automatic logic [7:0] mem_fn(input logic [15:0] a);
    return a[7:0] + a[15:8] + 8'h11;
  endfunction
  assign mem_rdata = mem_fn(mem_addr);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // read bytes stand from one rising edge to the next; look between edges
  always @(negedge core_clk) begin
    cyc_count = cyc_count + 1;
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (cyc_count == CYC_LIMIT) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: run did not finish in time", $time);
      complete_run();
    end
  end
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares = compares + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one command: offered at a falling edge, held until taken, then wait for done
  task automatic run_cmd(input sep_pkg::sep_cmd_type op, input logic clock_control_register_space,
                         input logic [15:0] addr, input logic [7:0] len, input logic [7:0] wd);
    int n;
    rd_q.delete();
    @(negedge core_clk);
    cmd_op = op;
    cmd_ccr = clock_control_register_space;
    cmd_addr = addr;
    cmd_len = len;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    for (n = 0; n < 100 && cmd_ready !== 1'b1; n++) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 60000 && done !== 1'b1; n++) @(negedge core_clk);
    chk({15'h0, done}, 16'h1, "command completion");
    chk({15'h0, cmd_ready}, 16'h1, "host idle after stop");
  endtask
  task automatic check_reads(input logic [15:0] addr, input int n);
    chk(16'(rd_q.size()), 16'(n), "read byte count");
    foreach (rd_q[i]) chk({8'h00, rd_q[i]}, {8'h00, mem_fn(addr + 16'(i))}, "read byte");
  endtask
  task automatic pop_word(input logic [7:0] exp);
    chk({15'h0, wr_valid}, 16'h1, "buffer valid");
    chk({8'h00, wr_data}, {8'h00, exp}, "buffered write byte");
    wr_ready = 1'b1;
    @(negedge core_clk);
    wr_ready = 1'b0;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic test_power_up_read();
    chk(mem_addr, 16'h0000, "counter after reset");
    run_cmd(sep_pkg::SEP_CMD_CUR_READ, 1'b0, 16'h0000, 8'h01, 8'h00);
    check_reads(16'h0000, 1);
    $display("test power_up_read done");
  endtask
  // address set at the top of the space, then a read that wraps
  task automatic test_set_addr_wrap();
    run_cmd(sep_pkg::SEP_CMD_SET_ADDR, 1'b0, 16'hFFFF, 8'h01, 8'h00);
    chk(mem_addr, 16'hFFFF, "counter after address set");
    run_cmd(sep_pkg::SEP_CMD_CUR_READ, 1'b0, 16'h0000, 8'h02, 8'h00);
    check_reads(16'hFFFF, 2);
    chk(mem_addr, 16'h0001, "counter after wrap");
    $display("test set_addr_wrap done");
  endtask
  // two writes into a stalled buffer; the second must poll through busy
  task automatic test_write_stall();
    int n;
    run_cmd(sep_pkg::SEP_CMD_WRITE, 1'b0, 16'h0010, 8'h01, 8'hA5);
    for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge core_clk);
    chk({15'h0, busy}, 16'h1, "busy after write stop");
    run_cmd(sep_pkg::SEP_CMD_WRITE, 1'b0, 16'h0011, 8'h01, 8'h5A);
    pop_word(8'hA5);
    pop_word(8'h5A);
    chk({15'h0, wr_valid}, 16'h0, "buffer empty after drain");
    $display("test write_stall done");
  endtask
  // random read of the control space, issued while programming runs and polled until it ends
  task automatic test_rand_read();
    run_cmd(sep_pkg::SEP_CMD_RAND_READ, 1'b1, 16'h0042, 8'h01, 8'h00);
    check_reads(16'h0042, 1);
    chk(mem_addr, 16'h0043, "counter after random read");
    $display("test rand_read done");
  endtask
  initial begin
    err_count = 0;
    compares = 0;
    cyc_count = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = sep_pkg::SEP_CMD_CUR_READ;
    cmd_ccr = 1'b0;
    cmd_addr = 16'h0000;
    cmd_len = 8'h01;
    cmd_wdata = 8'h00;
    wr_ready = 1'b0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    test_power_up_read();
    test_set_addr_wrap();
    test_write_stall();
    test_rand_read();
    complete_run();
  end
endmodule // tb
